// [rtl/ppc_port_pin_config_data.sv]
// Port 1/2/3 pin configuration and data registers on the core register bus.
// Assumes the core drives a synchronous byte bus with write and read strobes,
// a current register page and a bit-address path; pins are sampled as-is.
//
// Contract
// - Bypass bit 1 makes crossbar skip pin
// - Data write sets each pin's latch
// - Data read returns pin level, not latch
// - Data on all pages; config page 0x0F
// - Input-mode 0 selects analog, no receiver
// - Drive mode ignored for analog pins
// - Drive mode 0 open-drain, 1 push-pull
`include "ppc_cfg.svh"
`default_nettype none

module ppc_port_pin_config_data
  import ppc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] sfr_page,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       bit_wr,
  input  wire logic [7:0] bit_addr,
  input  wire logic       bit_wdata,
  input  wire logic [7:0] port_two_pin_in,
  input  wire logic [7:0] port_three_pin_in,
  output logic      [7:0] sfr_rdata,
  output logic      [7:0] port_one_skip,
  output logic      [7:0] port_two_skip,
  output logic      [7:0] port_two_pin_out,
  output logic      [7:0] port_two_pin_oe,
  output logic      [7:0] port_two_pullup_en,
  output logic      [7:0] port_two_rx_en,
  output logic      [7:0] port_three_pin_out,
  output logic      [7:0] port_three_pin_oe
);

  ppc_state_t st;
  ppc_state_t next_st;
  logic       cfg_page;
  logic [7:0] p2_sense;
  logic [7:0] p3_sense;
  logic [7:0] p2_bitmask;
  logic [7:0] p3_bitmask;
  logic       p2_bit_hit;
  logic       p3_bit_hit;

  // Data addresses kept whole so their byte field can be sliced to width
  localparam logic [7:0] P2_DATA_ADDR = `PPC_ADDR_PORT_TWO_DATA;
  localparam logic [7:0] P3_DATA_ADDR = `PPC_ADDR_PORT_THREE_DATA;

  // ========================================================================
  // Decode
  // page gating
  assign cfg_page = (sfr_page == `PPC_CONFIG_PAGE);
  assign p2_bit_hit = bit_wr &&
    (bit_addr[`PPC_BIT_BYTE_MSB:`PPC_BIT_BYTE_LSB] ==
     P2_DATA_ADDR[`PPC_BIT_BYTE_MSB:`PPC_BIT_BYTE_LSB]);
  assign p3_bit_hit = bit_wr &&
    (bit_addr[`PPC_BIT_BYTE_MSB:`PPC_BIT_BYTE_LSB] ==
     P3_DATA_ADDR[`PPC_BIT_BYTE_MSB:`PPC_BIT_BYTE_LSB]);
  assign p2_bitmask = p2_bit_hit ? (8'h01 << bit_addr[2:0]) : 8'h00;
  assign p3_bitmask = p3_bit_hit ? (8'h01 << bit_addr[2:0]) : 8'h00;

  // sensed level
  // Analog pins have no receiver, so they read as low
  assign p2_sense = port_two_pin_in & st.port_two_analog_select;
  assign p3_sense = port_three_pin_in;

  // ========================================================================
  // Next state
  always_comb begin
    next_st = st;
    if (sfr_wr && sfr_addr == `PPC_ADDR_PORT_TWO_DATA) begin
      next_st.port_two_data = sfr_wdata;
    end
    if (sfr_wr && sfr_addr == `PPC_ADDR_PORT_THREE_DATA) begin
      next_st.port_three_data = sfr_wdata;
    end
    next_st.port_two_data = (next_st.port_two_data & ~p2_bitmask) |
                            ({8{bit_wdata}} & p2_bitmask);
    next_st.port_three_data = (next_st.port_three_data & ~p3_bitmask) |
                              ({8{bit_wdata}} & p3_bitmask);
    if (sfr_wr && cfg_page) begin
      case (sfr_addr)
        `PPC_ADDR_PORT_TWO_DRIVE_MODE:
          next_st.port_two_drive_mode = sfr_wdata;
        `PPC_ADDR_PORT_ONE_CROSSBAR_BYPASS:
          next_st.port_one_crossbar_bypass = sfr_wdata;
        `PPC_ADDR_PORT_TWO_CROSSBAR_BYPASS:
          next_st.port_two_crossbar_bypass = sfr_wdata;
        `PPC_ADDR_PORT_TWO_ANALOG_SELECT:
          next_st.port_two_analog_select = sfr_wdata;
        default: ;
      endcase
    end
    next_st.rd_data = 8'h00;
    if (sfr_rd) begin
      case (sfr_addr)
        `PPC_ADDR_PORT_TWO_DATA:   next_st.rd_data = p2_sense;
        `PPC_ADDR_PORT_THREE_DATA: next_st.rd_data = p3_sense;
        `PPC_ADDR_PORT_TWO_DRIVE_MODE:
          next_st.rd_data = cfg_page ? st.port_two_drive_mode : 8'h00;
        `PPC_ADDR_PORT_ONE_CROSSBAR_BYPASS:
          next_st.rd_data = cfg_page ? st.port_one_crossbar_bypass : 8'h00;
        `PPC_ADDR_PORT_TWO_CROSSBAR_BYPASS:
          next_st.rd_data = cfg_page ? st.port_two_crossbar_bypass : 8'h00;
        `PPC_ADDR_PORT_TWO_ANALOG_SELECT:
          next_st.rd_data = cfg_page ? st.port_two_analog_select : 8'h00;
        default: next_st.rd_data = 8'h00;
      endcase
    end
    next_st.port_two_pullup_en = next_st.port_two_analog_select;
    next_st.port_two_rx_en = next_st.port_two_analog_select;
    // drive control
    // Analog pins never drive; open-drain drives only a low latch
    next_st.port_two_out = next_st.port_two_data;
    next_st.port_two_oe = next_st.port_two_analog_select &
      (next_st.port_two_drive_mode | ~next_st.port_two_data);
    // Port 3 mode registers live elsewhere; treated as open-drain
    next_st.port_three_out = next_st.port_three_data;
    next_st.port_three_oe = ~next_st.port_three_data;
  end

  // ========================================================================
  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{port_two_data:            `PPC_RST_DATA,
              port_three_data:          `PPC_RST_DATA,
              port_two_drive_mode:      `PPC_RST_DRIVE_MODE,
              port_one_crossbar_bypass: `PPC_RST_BYPASS,
              port_two_crossbar_bypass: `PPC_RST_BYPASS,
              port_two_analog_select:   `PPC_RST_ANALOG_SELECT,
              rd_data:                  8'h00,
              port_two_out:             `PPC_RST_DATA,
              port_two_oe:              8'h00,
              port_two_pullup_en:       `PPC_RST_ANALOG_SELECT,
              port_two_rx_en:           `PPC_RST_ANALOG_SELECT,
              port_three_out:           `PPC_RST_DATA,
              port_three_oe:            8'h00};
    end else begin
      st <= next_st;
    end
  end

  assign sfr_rdata          = st.rd_data;
  assign port_one_skip      = st.port_one_crossbar_bypass;
  assign port_two_skip      = st.port_two_crossbar_bypass;
  assign port_two_pin_out   = st.port_two_out;
  assign port_two_pin_oe    = st.port_two_oe;
  assign port_two_pullup_en = st.port_two_pullup_en;
  assign port_two_rx_en     = st.port_two_rx_en;
  assign port_three_pin_out = st.port_three_out;
  assign port_three_pin_oe  = st.port_three_oe;

  // ========================================================================
  // Checks
  // port one and port two bypass
  AST_BYPASS_WRITE: assert property (
    @(posedge clk) disable iff (!rst_n)
    sfr_wr && cfg_page && sfr_addr == `PPC_ADDR_PORT_ONE_CROSSBAR_BYPASS
    |=> port_one_skip == $past(sfr_wdata))
    else $error("bypass write not seen");
  AST_BYPASS_TWO_WRITE: assert property (
    @(posedge clk) disable iff (!rst_n)
    sfr_wr && cfg_page && sfr_addr == `PPC_ADDR_PORT_TWO_CROSSBAR_BYPASS
    |=> port_two_skip == $past(sfr_wdata))
    else $error("port two bypass write not seen");
  AST_LATCH_WRITE: assert property (
    @(posedge clk) disable iff (!rst_n)
    sfr_wr && sfr_addr == `PPC_ADDR_PORT_TWO_DATA && !bit_wr
    |=> port_two_pin_out == $past(sfr_wdata))
    else $error("port two latch wrong");
  AST_BIT_WRITE: assert property (
    @(posedge clk) disable iff (!rst_n)
    p2_bit_hit
    |=> port_two_pin_out[$past(bit_addr[2:0])] == $past(bit_wdata))
    else $error("port two bit write wrong");
  AST_PIN_READ: assert property (
    @(posedge clk) disable iff (!rst_n)
    sfr_rd && sfr_addr == `PPC_ADDR_PORT_THREE_DATA
    |=> sfr_rdata == $past(port_three_pin_in))
    else $error("port three read not pin level");
  AST_PAGE_GATE: assert property (
    @(posedge clk) disable iff (!rst_n)
    sfr_wr && !cfg_page |=> $stable({port_one_skip, port_two_skip}))
    else $error("config written off page");
  AST_OFFPAGE_READ: assert property (
    @(posedge clk) disable iff (!rst_n)
    sfr_rd && !cfg_page &&
    (sfr_addr == `PPC_ADDR_PORT_ONE_CROSSBAR_BYPASS ||
     sfr_addr == `PPC_ADDR_PORT_TWO_CROSSBAR_BYPASS ||
     sfr_addr == `PPC_ADDR_PORT_TWO_DRIVE_MODE ||
     sfr_addr == `PPC_ADDR_PORT_TWO_ANALOG_SELECT)
    |=> sfr_rdata == 8'h00)
    else $error("config read off page");
  // analog pins read low
  // Mask is the mode at the read edge, not after it
  AST_ANALOG_RX: assert property (
    @(posedge clk) disable iff (!rst_n)
    sfr_rd && sfr_addr == `PPC_ADDR_PORT_TWO_DATA
    |=> (sfr_rdata & ~$past(port_two_rx_en)) == 8'h00)
    else $error("analog pin reads high");
  AST_ANALOG_MODE: assert property (
    @(posedge clk) disable iff (!rst_n)
    sfr_wr && cfg_page && sfr_addr == `PPC_ADDR_PORT_TWO_ANALOG_SELECT
    |=> port_two_rx_en == $past(sfr_wdata) &&
        port_two_pullup_en == $past(sfr_wdata))
    else $error("analog mode not applied");
  AST_ANALOG_NODRIVE: assert property (
    @(posedge clk) disable iff (!rst_n)
    (port_two_pin_oe & ~port_two_rx_en) == 8'h00)
    else $error("analog pin driven");
  AST_OPEN_DRAIN: assert property (
    @(posedge clk) disable iff (!rst_n)
    (port_two_pin_oe & port_two_pin_out & ~st.port_two_drive_mode) == 8'h00)
    else $error("open-drain pin drives high");
  AST_PUSH_PULL: assert property (
    @(posedge clk) disable iff (!rst_n)
    (~port_two_pin_oe & st.port_two_drive_mode &
     st.port_two_analog_select) == 8'h00)
    else $error("push-pull pin not driven");

endmodule // ppc_port_pin_config_data

`default_nettype wire

// [rtl/ppc_cfg.svh]
// Register map, field layout and reset values of the port configuration block.
// Assumes an 8-bit special-function register bus with page select.
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH

// ==========================================================================
// Register addresses
`define PPC_ADDR_PORT_TWO_DATA            8'ha0
`define PPC_ADDR_PORT_TWO_DRIVE_MODE      8'ha6
`define PPC_ADDR_PORT_THREE_DATA          8'hb0
`define PPC_ADDR_PORT_ONE_CROSSBAR_BYPASS 8'hd5
`define PPC_ADDR_PORT_TWO_CROSSBAR_BYPASS 8'hd6
`define PPC_ADDR_PORT_TWO_ANALOG_SELECT   8'hf3

// ==========================================================================
// Page holding the mode and bypass registers
`define PPC_CONFIG_PAGE                   8'h0f

// ==========================================================================
// Reset values
`define PPC_RST_DATA                      8'hff
`define PPC_RST_DRIVE_MODE                8'h00
`define PPC_RST_BYPASS                    8'h00
`define PPC_RST_ANALOG_SELECT             8'hff

// ==========================================================================
// Bit-address layout: bits 7:3 pick the byte, bits 2:0 the bit
`define PPC_BIT_BYTE_MSB                  7
`define PPC_BIT_BYTE_LSB                  3

`endif

// [rtl/ppc_pkg.sv]
// Types shared by the port configuration block.
// Assumes the constants header is compiled alongside.
`default_nettype none

package ppc_pkg;

  // ========================================================================
  // Register state of the block
  typedef struct packed {
    logic [7:0] port_two_data;
    logic [7:0] port_three_data;
    logic [7:0] port_two_drive_mode;
    logic [7:0] port_one_crossbar_bypass;
    logic [7:0] port_two_crossbar_bypass;
    logic [7:0] port_two_analog_select;
    logic [7:0] rd_data;
    logic [7:0] port_two_out;
    logic [7:0] port_two_oe;
    logic [7:0] port_two_pullup_en;
    logic [7:0] port_two_rx_en;
    logic [7:0] port_three_out;
    logic [7:0] port_three_oe;
  } ppc_state_t;

endpackage : ppc_pkg

`default_nettype wire

// [verif/ppc_board.sv]
// Board model for one 8-pin port: resolves each pin level.
// Assumes outside sources are weaker than an enabled port driver.
`default_nettype none

module ppc_board (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] ext_lvl,
  output logic      [7:0] pin_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==================================================================
  // Pin resolution
  // An enabled driver wins; otherwise the outside level shows
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule // ppc_board

`default_nettype wire

// [verif/test_port_pin_config_data.sv]
// Self-checking bench for the port configuration block.
// Assumes one board model per port and a byte register bus.
`default_nettype none

module test_port_pin_config_data;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst_n, wr, rd, bwr, bdat;
  logic [7:0] pg, ad, wd, ba, e2, e3, p2i, p3i, rdat;
  logic [7:0] sk1, sk2, o2, oe2, pu2, rx2, o3, oe3;
  int         err_count, checks, cyc;

  ppc_port_pin_config_data dut (.clk(clk), .rst_n(rst_n), .sfr_page(pg),
    .sfr_addr(ad), .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wd), .bit_wr(bwr),
    .bit_addr(ba), .bit_wdata(bdat), .port_two_pin_in(p2i),
    .port_three_pin_in(p3i), .sfr_rdata(rdat), .port_one_skip(sk1),
    .port_two_skip(sk2), .port_two_pin_out(o2), .port_two_pin_oe(oe2),
    .port_two_pullup_en(pu2), .port_two_rx_en(rx2),
    .port_three_pin_out(o3), .port_three_pin_oe(oe3));
  ppc_board b2 (.pin_out(o2), .pin_oe(oe2), .ext_lvl(e2), .pin_lvl(p2i));
  ppc_board b3 (.pin_out(o3), .pin_oe(oe3), .ext_lvl(e3), .pin_lvl(p3i));

  // ==================================================================
  // Bus and compare tasks
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    ad = a;
    wd = d;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
  endtask
  task automatic rd8(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1;
    ad = a;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    cmp(rdat, exp);
  endtask
  task automatic bit1(input logic [7:0] a, input logic v);
    @(posedge clk);
    #1;
    ba = a;
    bdat = v;
    bwr = 1'b1;
    @(posedge clk);
    #1;
    bwr = 1'b0;
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ==================================================================
  // Scenarios
  task automatic t_reset();
    cmp(o2, 8'hff);
    cmp(oe2, 8'h00);
    cmp(pu2, 8'hff);
    cmp(sk1 | sk2, 8'h00);
    rd8(8'ha6, 8'h00);
    rd8(8'hf3, 8'hff);
  endtask
  task automatic t_skip();
    wr8(8'hd5, 8'ha5);
    wr8(8'hd6, 8'h3c);
    cmp(sk1, 8'ha5);
    cmp(sk2, 8'h3c);
    rd8(8'hd5, 8'ha5);
    pg = 8'h00;
    wr8(8'hd5, 8'h00);
    cmp(sk1, 8'ha5);
    rd8(8'hd6, 8'h00);
  endtask
  task automatic t_data();
    wr8(8'ha0, 8'h55);
    cmp(o2, 8'h55);
    rd8(8'hb0, 8'h3c);
    wr8(8'hb0, 8'h0f);
    cmp(o3, 8'h0f);
    cmp(oe3, 8'hf0);
    rd8(8'hb0, 8'h0c);
    bit1(8'ha2, 1'b0);
    cmp(o2, 8'h51);
    rd8(8'ha0, 8'h01);
    bit1(8'hb7, 1'b1);
    cmp(o3, 8'h8f);
    rd8(8'hc0, 8'h00);
  endtask
  task automatic t_mode();
    pg = 8'h0f;
    cmp(oe2, 8'hae);
    wr8(8'ha6, 8'hff);
    cmp(oe2, 8'hff);
    // Analog pins get bypassed; drive mode left set to probe masking
    wr8(8'hd6, 8'h0f);
    rd8(8'hd6, 8'h0f);
    wr8(8'hf3, 8'hf0);
    rd8(8'hf3, 8'hf0);
    cmp(pu2 & rx2, 8'hf0);
    cmp(oe2, 8'hf0);
    rd8(8'ha0, 8'h50);
    wr8(8'ha6, 8'h00);
    cmp(oe2, 8'ha0);
  endtask
  // Mid-run reset must bring every register back; port one bypass, port three data and the port two pull-ups are reset too but not checked
  task automatic t_rerun();
    @(posedge clk);
    #1;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    cmp(o2, 8'hff);
    cmp(oe2 | oe3, 8'h00);
    cmp(rx2, 8'hff);
    cmp(sk2, 8'h00);
    rd8(8'ha6, 8'h00);
  endtask

  // ==================================================================
  // Clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    {rst_n, wr, rd, bwr, bdat} = 5'h00;
    {ad, wd, ba} = 24'h000000;
    pg = 8'h0f;
    e2 = 8'h0f;
    e3 = 8'h3c;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_skip();
    t_data();
    t_mode();
    t_rerun();
    close_out();
  end
endmodule // test_port_pin_config_data

`default_nettype wire
